// ---- verilog/stnpp_pkg.sv ----
// shared constants, encodings and carrier types of the stn colour pixel pipeline
package stnpp_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses, one 32-bit word each)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_RED_LEVEL_TABLE = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_GREEN_LEVEL_TABLE = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_BLUE_LEVEL_TABLE = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h10;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_DISP_LSB = 0;
  localparam int CTRL_DEPTH_LSB = 2;
  localparam int STAT_UNDERRUN_BIT = 0;
  localparam int STAT_UPPER_RDY_BIT = 1;
  localparam int STAT_LOWER_RDY_BIT = 2;
  localparam int STAT_SEQ_LSB = 16;
  localparam logic [31:0] RST_RED_LEVEL_TABLE = 32'h0000_0000;
  localparam logic [31:0] RST_GREEN_LEVEL_TABLE = 32'h0000_0000;
  localparam logic [15:0] RST_BLUE_LEVEL_TABLE = 16'h0000;

  // ----------------------------------------------------------------
  // frame duty control: numerator and denominator per level 15..0
  // ----------------------------------------------------------------
  localparam logic [15:0][2:0] FRC_NUM = {3'h1, 3'h6, 3'h4, 3'h3, 3'h5, 3'h2, 3'h3, 3'h4,
                                          3'h1, 3'h3, 3'h2, 3'h1, 3'h1, 3'h1, 3'h1, 3'h0};
  localparam logic [15:0][2:0] FRC_DEN = {3'h1, 3'h7, 3'h5, 3'h4, 3'h7, 3'h3, 3'h5, 3'h7,
                                          3'h2, 3'h7, 3'h5, 3'h3, 3'h4, 3'h5, 3'h7, 3'h2};
  localparam logic [8:0] FRC_PERIOD = 9'h1a4; // 420 frames, every denominator divides it
  localparam logic [5:0] WORD_BITS = 6'h20;

  // ----------------------------------------------------------------
  // modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {DISP_DUAL4 = 2'h0, DISP_SINGLE4 = 2'h1, DISP_SINGLE8 = 2'h2} stnpp_disp_type;
  typedef enum logic [1:0] {DEPTH_MONO = 2'h0, DEPTH_C256 = 2'h1, DEPTH_C4096 = 2'h2} stnpp_depth_type;

  // ----------------------------------------------------------------
  // carriers and state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } stnpp_reg_req_type;

  typedef struct packed {
    logic [31:0] word;
    logic valid;
  } stnpp_word_type;

  typedef struct packed {
    logic [1:0] disp;
    logic [1:0] depth;
  } stnpp_cfg_type;

  typedef logic [7:0][2:0] stnpp_phase_type;

  typedef struct packed {
    logic [31:0] word;  // remaining bits, next item at the top
    logic wvalid;
    logic ready;        // buffer handshake, equals not wvalid while enabled, except lower half low in the first cycle after reset
    logic [5:0] rem;    // bits left in the word
    logic [1:0] sub;    // subpixel within a 256-colour pixel
    logic [7:0] acc;    // serialised bits, oldest at the top of the lane
    logic [3:0] cnt;    // bits collected for the next beat
    logic [2:0] col;    // subpixel column, spreads dither spatially
  } stnpp_half_type;

  typedef struct packed {
    stnpp_cfg_type cfg;
    stnpp_cfg_type cfg_act;
    logic [31:0] red;
    logic [31:0] grn;
    logic [15:0] blu;
    stnpp_phase_type ph;
    logic [8:0] frame_seq;
    stnpp_half_type up;
    stnpp_half_type lo;
    logic [7:0] pdata;
    logic pstrobe;
    logic [31:0] rdata;
    logic underrun;
  } stnpp_state_type;

endpackage

// ---- verilog/stnpp_pipeline.sv ----
// pixel lookup, dither and panel serialiser of the stn colour pixel pipeline
//
// Implementation choices: the placing of the registers and the address-and-strobe port.

// What this block does
// - 256-colour pixel splits into red index 3 bits, green 3 bits, blue 2 bits.
// - each 256-colour index goes through its own level table, red, green or blue.
// - red table holds eight 4-bit levels; index n takes bits 4n+3 down to 4n.
// - green table is laid out exactly like the red one.
// - blue table holds four 4-bit levels picked by the 2-bit blue index.
// - 4096-colour pixel is 12 bits, 4 per colour, dithered and duty controlled.
// - 4096-colour components bypass all tables and act directly as levels.
// - every non-monochrome depth passes the dither stage; monochrome skips it.
// - dither spreads on-frames over time to reduce visible flicker.
// - a level shows by lighting a pixel in a fixed subset of repeating frames.
// - duty follows the fixed level table, e.g. level 14 on in 6 of 7.
// - 4-bit dual scan drives 4 bits per half at once on all eight lines.
// - 4-bit single scan uses only the four low lines; high lines stay unused.
// - 8-bit single scan drives all eight lines with successive line data.
// - colour pixels shift three consecutive subpixel bits red, green, blue.
// - 4096-colour bit order follows the order stored in the video buffer.
// - each word goes out bit 31 first, words in order.
// - single scan uses only the upper buffer; dual scan uses upper and lower.
module stnpp_pipeline (
  // clock, reset and enable
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // register port
  input wire stnpp_pkg::stnpp_reg_req_type reg_req,
  output logic [31:0] reg_rdata,
  // frame timing from the timing generator
  input wire logic frame_start,
  input wire logic shift_req,
  // pixel words from the upper and lower buffers
  input wire stnpp_pkg::stnpp_word_type upper_in,
  output logic upper_ready,
  input wire stnpp_pkg::stnpp_word_type lower_in,
  output logic lower_ready,
  // panel data
  output logic [7:0] panel_data_lines,
  output logic panel_data_strobe
);
  import stnpp_pkg::*;

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------

  // small modulo by repeated subtraction, inputs stay below 16 times d
  function automatic logic [5:0] mod_small(logic [5:0] v, logic [2:0] d);
    logic [5:0] r;
    r = v;
    for (int i = 0; i < 16; i++) begin
      if (r >= {3'h0, d}) begin
        r = r - {3'h0, d};
      end
    end
    return r;
  endfunction

  // one 4-bit field of a level table selected by its index
  function automatic logic [3:0] level_field(logic [31:0] table_v, logic [2:0] idx);
    logic [31:0] sh;
    sh = table_v >> {idx, 2'h0};
    return sh[3:0];
  endfunction

  // on or off for a level in this frame at this column
  function automatic logic frc_bit(logic [3:0] lvl, stnpp_phase_type ph, logic [2:0] col);
    logic [2:0] den;
    logic [2:0] num;
    logic [5:0] p;
    logic [8:0] prod;
    den = FRC_DEN[lvl];
    num = FRC_NUM[lvl];
    // frame phase plus column offset staggers neighbours in time
    p = mod_small({3'h0, ph[den]} + {3'h0, col}, den);
    // spread num on-frames evenly over den frames
    prod = {3'h0, p} * {6'h0, num};
    p = mod_small(prod[5:0], den);
    return p < {3'h0, num};
  endfunction

  // one cycle of a buffer half: take a word, make one subpixel bit, hand a beat
  function automatic stnpp_half_type half_step(stnpp_half_type h, stnpp_word_type in_w, logic en,
                                               logic take, stnpp_cfg_type cfg, logic [31:0] red,
                                               logic [31:0] grn, logic [15:0] blu,
                                               stnpp_phase_type ph);
    stnpp_half_type n;
    logic bit_v;
    logic [3:0] lvl;
    logic [5:0] step;
    logic [3:0] lane;
    n = h;
    bit_v = 1'b0;
    lvl = 4'h0;
    step = 6'h0;
    lane = (cfg.disp == DISP_SINGLE8) ? 4'h8 : 4'h4;
    if (take) begin
      n.cnt = 4'h0;
    end
    if (!en) begin
      n = '0;
    end else if (!h.wvalid) begin
      // new word accepted on ready and valid
      if (in_w.valid && h.ready) begin
        n.word = in_w.word;
        n.wvalid = 1'b1;
        n.rem = WORD_BITS;
        n.sub = 2'h0;
      end
    end else if (n.cnt < lane) begin
      // items are taken from the top of the word, bit 31 first
      case (cfg.depth)
        DEPTH_MONO: begin
          bit_v = h.word[31];
          step = 6'h1;
        end
        DEPTH_C4096: begin
          lvl = h.word[31:28];
          step = 6'h4;
        end
        default: begin
          // red 7:5, green 4:2, blue 1:0 of each byte, sent red, green, blue
          case (h.sub)
            2'h0: lvl = level_field(red, h.word[31:29]);
            2'h1: lvl = level_field(grn, h.word[28:26]);
            default: lvl = level_field({16'h0, blu}, {1'b0, h.word[25:24]});
          endcase
          step = (h.sub == 2'h2) ? 6'h8 : 6'h0;
          n.sub = (h.sub == 2'h2) ? 2'h0 : h.sub + 2'h1;
        end
      endcase
      if (cfg.depth != DEPTH_MONO) begin
        bit_v = frc_bit(lvl, ph, h.col);
      end
      n.acc = {h.acc[6:0], bit_v};
      n.cnt = n.cnt + 4'h1;
      n.col = h.col + 3'h1;
      n.word = h.word << step;
      n.rem = h.rem - step;
      if (n.rem == 6'h0) begin
        n.wvalid = 1'b0;
      end
    end
    n.ready = en && !n.wvalid;
    return n;
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  stnpp_state_type state_reg;
  stnpp_state_type state_next;

  // combinational view of the current state
  logic dual;
  logic [3:0] lane;
  logic up_full;
  logic lo_full;
  logic beat_ok;
  logic take;

  assign dual = (state_reg.cfg_act.disp == DISP_DUAL4);
  assign lane = (state_reg.cfg_act.disp == DISP_SINGLE8) ? 4'h8 : 4'h4;
  assign up_full = (state_reg.up.cnt == lane);
  assign lo_full = (state_reg.lo.cnt == lane);
  // a dual scan beat needs both halves at once
  assign beat_ok = up_full && (!dual || lo_full);
  assign take = shift_req && beat_ok;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.pstrobe = 1'b0;

    // register writes
    if (reg_req.wr) begin
      case (reg_req.addr)
        OFS_CTRL: begin
          state_next.cfg.disp = reg_req.wdata[CTRL_DISP_LSB +: 2];
          state_next.cfg.depth = reg_req.wdata[CTRL_DEPTH_LSB +: 2];
        end
        OFS_RED_LEVEL_TABLE: state_next.red = reg_req.wdata;
        OFS_GREEN_LEVEL_TABLE: state_next.grn = reg_req.wdata;
        OFS_BLUE_LEVEL_TABLE: state_next.blu = reg_req.wdata[15:0];
        OFS_STATUS: begin
          if (reg_req.wdata[STAT_UNDERRUN_BIT]) begin
            state_next.underrun = 1'b0;
          end
        end
        default: state_next.underrun = state_next.underrun;
      endcase
    end

    // register reads, data stand in the following cycle only
    state_next.rdata = 32'h0000_0000;
    if (reg_req.rd) begin
      case (reg_req.addr)
        OFS_CTRL: begin
          state_next.rdata[CTRL_DISP_LSB +: 2] = state_reg.cfg.disp;
          state_next.rdata[CTRL_DEPTH_LSB +: 2] = state_reg.cfg.depth;
        end
        OFS_RED_LEVEL_TABLE: state_next.rdata = state_reg.red;
        OFS_GREEN_LEVEL_TABLE: state_next.rdata = state_reg.grn;
        OFS_BLUE_LEVEL_TABLE: state_next.rdata[15:0] = state_reg.blu;
        OFS_STATUS: begin
          state_next.rdata[STAT_UNDERRUN_BIT] = state_reg.underrun;
          state_next.rdata[STAT_UPPER_RDY_BIT] = up_full;
          state_next.rdata[STAT_LOWER_RDY_BIT] = lo_full;
          state_next.rdata[STAT_SEQ_LSB +: 9] = state_reg.frame_seq;
        end
        default: state_next.rdata = 32'h0000_0000;
      endcase
    end

    // frame boundary: display and depth settings take effect and the sequence advances
    if (frame_start) begin
      state_next.cfg_act = state_reg.cfg;
      state_next.frame_seq = (state_reg.frame_seq == FRC_PERIOD - 9'h1) ? 9'h0 :
                             state_reg.frame_seq + 9'h1;
      for (int d = 1; d < 8; d++) begin
        state_next.ph[d] = (state_reg.ph[d] == 3'(d - 1)) ? 3'h0 : state_reg.ph[d] + 3'h1;
      end
    end

    // both halves work from the display and depth settings of the running frame and the current level tables
    state_next.up = half_step(state_reg.up, upper_in, 1'b1, take, state_reg.cfg_act,
                              state_reg.red, state_reg.grn, state_reg.blu, state_reg.ph);
    state_next.lo = half_step(state_reg.lo, lower_in, dual, take, state_reg.cfg_act,
                              state_reg.red, state_reg.grn, state_reg.blu, state_reg.ph);

    // panel beat: in dual scan upper half on the high lines, lower half on the low lines
    if (take) begin
      state_next.pstrobe = 1'b1;
      case (state_reg.cfg_act.disp)
        DISP_DUAL4: state_next.pdata = {state_reg.up.acc[3:0], state_reg.lo.acc[3:0]};
        DISP_SINGLE4: state_next.pdata = {4'h0, state_reg.up.acc[3:0]};
        default: state_next.pdata = state_reg.up.acc;
      endcase
    end

    // a shift request with no beat ready is an underrun, set beats clear
    if (shift_req && !beat_ok) begin
      state_next.underrun = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '0;
      state_reg.red <= RST_RED_LEVEL_TABLE;
      state_reg.grn <= RST_GREEN_LEVEL_TABLE;
      state_reg.blu <= RST_BLUE_LEVEL_TABLE;
      state_reg.up.ready <= 1'b1;
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all straight from the state register
  // ----------------------------------------------------------------
  assign reg_rdata = state_reg.rdata;
  assign upper_ready = state_reg.up.ready;
  assign lower_ready = state_reg.lo.ready;
  assign panel_data_lines = state_reg.pdata;
  assign panel_data_strobe = state_reg.pstrobe;

endmodule

// ---- bench/stnpp_pipeline_checker.sv ----
// port-level checks of the stn colour pixel pipeline
module stnpp_pipeline_checker
  import stnpp_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // register port
  input wire stnpp_pkg::stnpp_reg_req_type reg_req,
  input wire logic [31:0] reg_rdata,
  // timing and buffers
  input wire logic frame_start,
  input wire logic shift_req,
  input wire stnpp_pkg::stnpp_word_type upper_in,
  input wire logic upper_ready,
  input wire stnpp_pkg::stnpp_word_type lower_in,
  input wire logic lower_ready,
  // panel side
  input wire logic [7:0] panel_data_lines,
  input wire logic panel_data_strobe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] disp_w_reg;
  logic [1:0] disp_a_reg;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // display type as written, and as applied at the next frame start
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      disp_w_reg <= 2'h0;
      disp_a_reg <= 2'h0;
    end else if (clk_en) begin
      if (reg_req.wr && reg_req.addr == OFS_CTRL) disp_w_reg <= reg_req.wdata[1:0];
      if (frame_start) disp_a_reg <= disp_w_reg;
    end
  end
  a_read_idle: assert property (clk_en && !reg_req.rd |=> reg_rdata == 32'h0)
    else $error("read data not zero outside a read slot");
  a_unmapped_read: assert property (clk_en && reg_req.rd && reg_req.addr == 8'h14 |=> reg_rdata == 32'h0)
    else $error("unmapped read returned data");
  a_strobe_pulse: assert property (panel_data_strobe |=> !panel_data_strobe)
    else $error("panel strobe longer than one cycle");
  a_strobe_cause: assert property (panel_data_strobe |-> $past(shift_req && clk_en))
    else $error("panel strobe without a beat request");
  a_data_hold: assert property (!panel_data_strobe |-> $stable(panel_data_lines))
    else $error("panel data moved between beats");
  a_single4_high: assert property (panel_data_strobe && disp_a_reg == DISP_SINGLE4 |-> panel_data_lines[7:4] == 4'h0)
    else $error("high data lines used in 4-bit single scan");
  a_lower_idle: assert property (disp_a_reg != DISP_DUAL4 && $past(disp_a_reg) != DISP_DUAL4 |-> !lower_ready)
    else $error("lower buffer ready outside dual scan");
  a_upper_take: assert property (clk_en && upper_in.valid && upper_ready |=> !upper_ready [*2])
    else $error("upper ready did not drop after a take");
  c_beat: cover property (panel_data_strobe && disp_a_reg == DISP_SINGLE8);
  c_dual_beat: cover property (panel_data_strobe && disp_a_reg == DISP_DUAL4 && lower_in.valid);
  c_read: cover property (reg_req.rd ##1 reg_rdata != 32'h0);
endmodule

// ---- bench/stnpp_panel_model.sv ----
// panel driver model: asks for beats and records what the pipeline sends
module stnpp_panel_model (
  // clock and pace
  input wire logic sys_clk,
  input wire logic slow,
  // beat request and panel data
  output logic shift_req,
  input wire logic [7:0] panel_data_lines,
  input wire logic panel_data_strobe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] beats[$];
  logic [2:0] pace = 3'h0;
  initial shift_req = 1'b0;
  // request a beat every cycle, or one in eight when slow
  always @(posedge sys_clk) begin
    pace <= pace + 3'h1;
    shift_req <= !slow || pace == 3'h0;
    if (panel_data_strobe) beats.push_back(panel_data_lines);
  end
endmodule

// ---- bench/tb.sv ----
// self-checking bench of the pixel pipeline with a panel driver model
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import stnpp_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic frame_start = 1'b0;
  logic slow = 1'b0;
  logic ce = 1'b1;
  stnpp_reg_req_type req = '0;
  stnpp_word_type up = '0;
  stnpp_word_type lo = '0;
  logic [31:0] reg_rdata;
  logic upper_ready, lower_ready, shift_req, strobe;
  logic [7:0] pdl;
  logic [31:0] uq[$], lq[$];
  bit ub[$], lb[$];
  logic [7:0] msk[3];
  int error_cnt = 0, checked = 0, cyc = 0;
  always #2 sys_clk = ~sys_clk;
  stnpp_pipeline dut (.sys_clk, .rst_n, .clk_en(ce), .reg_req(req), .reg_rdata, .frame_start, .shift_req,
    .upper_in(up), .upper_ready, .lower_in(lo), .lower_ready, .panel_data_lines(pdl), .panel_data_strobe(strobe));
  stnpp_panel_model panel (.sys_clk, .slow, .shift_req, .panel_data_lines(pdl), .panel_data_strobe(strobe));
  task automatic close_out();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge sys_clk);
    req.wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge sys_clk);
    req.rd <= 1'b0;
    @(posedge sys_clk);
    d = reg_rdata;
  endtask
  task automatic frame();
    frame_start <= 1'b1;
    @(posedge sys_clk);
    frame_start <= 1'b0;
    @(posedge sys_clk);
  endtask
  // draw a word for one half and queue the serial bits it must give
  task automatic add(input bit h, input int dp);
    logic [31:0] w;
    logic [7:0] b;
    bit q[$];
    w = $urandom();
    for (int i = 7; i >= 0; i--) begin
      if (dp == 2) w[4*i+3 -: 4] = {4{w[4*i]}};
      if (dp == 2) q.push_back(w[4*i]);
    end
    for (int i = 31; i >= 0 && dp == 0; i--) q.push_back(w[i]);
    for (int p = 3; p >= 0 && dp == 1; p--) begin
      b = w[8*p+7 -: 8];
      q.push_back(msk[0][b[7:5]]);
      q.push_back(msk[1][b[4:2]]);
      q.push_back(msk[2][b[1:0]]);
    end
    if (h) lq.push_back(w);
    else uq.push_back(w);
    if (h) lb = {lb, q};
    else ub = {ub, q};
  endtask
  // one mode: random all-on or all-off levels, words on the upper half and in dual scan the lower, beats checked
  task automatic stream(input int dsp, input int dp);
    logic [31:0] t;
    logic [7:0] e;
    int bw;
    for (int c = 0; c < 3; c++) begin
      msk[c] = $urandom();
      for (int n = 0; n < 8; n++) t[4*n +: 4] = {4{msk[c][n]}};
      wr(OFS_RED_LEVEL_TABLE + 8'(4*c), t);
    end
    wr(OFS_CTRL, 32'(dp * 4 + dsp));
    frame();
    panel.beats.delete();
    slow <= 1'($urandom());
    for (int i = 0; i < 4; i++) begin
      add(0, dp);
      if (dsp == 0) add(1, dp);
    end
    bw = dsp == 2 ? 8 : 4;
    for (int k = 0; k < 3000 && panel.beats.size() < ub.size() / bw; k++) @(posedge sys_clk);
    cmp(panel.beats.size(), ub.size() / bw);
    while (panel.beats.size() > 0 && ub.size() >= bw) begin
      e = 8'h0;
      for (int k = bw - 1; k >= 0; k--) e[k + (dsp == 0 ? 4 : 0)] = ub.pop_front();
      for (int k = 3; k >= 0 && dsp == 0; k--) e[k] = lb.pop_front();
      cmp(panel.beats.pop_front(), e);
    end
    ub.delete();
    lb.delete();
  endtask
  // offer queued words to each half, a new one only after the last was taken
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (!up.valid || upper_ready) begin
      up.valid <= uq.size() > 0;
      if (uq.size() > 0) up.word <= uq.pop_front();
    end
    if (!lo.valid || lower_ready) begin
      lo.valid <= lq.size() > 0;
      if (lq.size() > 0) lo.word <= lq.pop_front();
    end
    if (cyc == 40000) begin
      error_cnt++;
      close_out();
    end
  end
  // main sequence: registers, frame counter, then every display and depth
  initial begin
    logic [31:0] d, s0;
    logic [7:0] e;
    int on[8] = '{default: 0};
    void'($urandom(71));
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    for (int c = 0; c < 3; c++) begin
      rd(OFS_RED_LEVEL_TABLE + 8'(4*c), d);
      cmp(d, 32'h0);
    end
    wr(OFS_BLUE_LEVEL_TABLE, 32'hffff_a5c3);
    rd(OFS_BLUE_LEVEL_TABLE, d);
    cmp(d, 32'h0000_a5c3);
    wr(8'h14, 32'hffff_ffff);
    rd(8'h14, d);
    cmp(d, 32'h0);
    // a write while the clock enable is low must be ignored
    ce <= 1'b0;
    wr(OFS_RED_LEVEL_TABLE, 32'hffff_ffff);
    ce <= 1'b1;
    rd(OFS_RED_LEVEL_TABLE, d);
    cmp(d, 32'h0);
    rd(OFS_STATUS, s0);
    repeat (3) frame();
    rd(OFS_STATUS, d);
    cmp(d[24:16], (s0[24:16] + 3) % 420);
    repeat (417) frame();
    rd(OFS_STATUS, d);
    cmp(d[24:16], s0[24:16]);
    for (int m = 0; m < 9; m++) stream(m % 3, m / 3);
    // level 14 on every component, one word a frame over a seven-frame period
    wr(OFS_CTRL, 32'(2 * 4 + 2));
    for (int f = 0; f < 7; f++) begin
      frame();
      panel.beats.delete();
      uq.push_back(32'heeee_eeee);
      for (int k = 0; k < 200 && panel.beats.size() == 0; k++) @(posedge sys_clk);
      e = (panel.beats.size() > 0) ? panel.beats.pop_front() : 8'h0;
      for (int b = 0; b < 8; b++) on[b] += e[b];
    end
    for (int b = 0; b < 8; b++) cmp(on[b], 6);
    close_out();
  end
endmodule
bind stnpp_pipeline stnpp_pipeline_checker chk (.sys_clk, .rst_n, .clk_en, .reg_req, .reg_rdata, .frame_start,
  .shift_req, .upper_in, .upper_ready, .lower_in, .lower_ready, .panel_data_lines, .panel_data_strobe);
